// ---- hw/comm_fault_ctrl.sv ----
module comm_fault_ctrl #(
	parameter int unsigned TICK_CYCLES = comm_fault_pkg::TICK_CYCLES_DEF,
	parameter int unsigned HOUR_TICKS = comm_fault_pkg::HOUR_TICKS_DEF,
	parameter logic [comm_fault_pkg::CODE_W-1:0] CIRC_CODE = comm_fault_pkg::CIRC_FAULT_CODE_DEF
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic line_err_pin,
	input wire logic circ_fault_pin,
	input wire logic other_fault,
	input wire logic net_mode,
	input wire logic [comm_fault_pkg::WAIT_W-1:0] error_wait_time,
	input wire comm_fault_pkg::stop_mode_t stop_mode_select,
	input wire logic motor_stopped,
	input wire logic count_clear,
	input wire logic [comm_fault_pkg::COUNT_W-1:0] nv_count_in,
	input wire logic run_cmd_in,
	input wire logic [comm_fault_pkg::SPEED_W-1:0] speed_cmd_in,
	output logic coast_cmd,
	output logic decel_cmd,
	output logic accel_restart,
	output logic alarm_output,
	output logic fault_bit,
	output logic line_error_fault,
	output logic circuit_fault_ind,
	output logic drive_trip,
	output logic comm_halt,
	output logic run_cmd_out,
	output logic [comm_fault_pkg::SPEED_W-1:0] speed_cmd_out,
	output logic hist_write,
	output logic hist_temp,
	output logic hist_restore,
	output logic [comm_fault_pkg::CODE_W-1:0] hist_code,
	output logic [comm_fault_pkg::COUNT_W-1:0] error_count_value,
	output logic nv_save,
	output logic [comm_fault_pkg::COUNT_W-1:0] nv_save_data
);
	import comm_fault_pkg::*;

	typedef struct packed {
		logic [1:0] le_sync;
		logic [1:0] cf_sync;
		ctrl_state_t st;
		stop_mode_t mode;
		logic coast;
		logic decel;
		logic restart;
		logic alarm;
		logic line_ind;
		logic circ_ind;
		logic trip;
		logic halt;
		logic run_cmd;
		logic [SPEED_W-1:0] speed;
		logic hist_wr;
		logic hist_tmp;
		logic hist_rst;
		logic [CODE_W-1:0] code;
	} ctrl_t;

	ctrl_t s_r, s_nxt;
	logic le;
	logic cf;
	logic trip_nxt;

	comm_fault_if lk();

	// ==========================================================
	// Submodules
	wait_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_wait (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.lk(lk)
	);

	err_counter #(
		.HOUR_TICKS(HOUR_TICKS)
	) u_count (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.lk(lk)
	);

	assign le = s_r.le_sync[1];
	assign cf = s_r.cf_sync[1];
	assign lk.line_err_s = le;
	assign lk.wait_time = (error_wait_time > WAIT_MAX) ? WAIT_MAX : error_wait_time;
	assign lk.clear_req = count_clear;
	assign lk.nv_load = nv_count_in;

	// ==========================================================
	// Reaction sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.le_sync = {s_r.le_sync[0], line_err_pin};
		s_nxt.cf_sync = {s_r.cf_sync[0], circ_fault_pin};
		s_nxt.restart = 1'b0;
		s_nxt.hist_wr = 1'b0;
		s_nxt.hist_tmp = 1'b0;
		s_nxt.hist_rst = 1'b0;
		// Command frozen while the link is bad, reused on restart
		if (s_r.st == ST_RUN && !le) begin
			s_nxt.run_cmd = run_cmd_in;
			s_nxt.speed = speed_cmd_in;
		end
		unique case (s_r.st)
			ST_RUN: begin
				if (cf && net_mode) begin
					if (stop_mode_select inside {STOP_COAST, STOP_CONTINUE}) begin
						s_nxt.st = ST_CIRC_TRIP;
					end else begin
						s_nxt.st = ST_CIRC_DECEL;
					end
				end else if (lk.expired && net_mode) begin
					s_nxt.mode = stop_mode_select;
					unique case (stop_mode_select)
						STOP_COAST: begin
							s_nxt.st = ST_LINE_TRIP;
						end
						STOP_DECEL_TRIP: begin
							s_nxt.st = ST_LINE_DECEL;
						end
						STOP_DECEL_RESUME: begin
							s_nxt.st = ST_LINE_DECEL;
							s_nxt.hist_tmp = 1'b1;
							s_nxt.code = LINE_FAULT_CODE;
						end
						STOP_CONTINUE: begin
							s_nxt.st = ST_RUN;
						end
					endcase
				end
			end
			ST_LINE_DECEL: begin
				if (s_r.mode == STOP_DECEL_RESUME && !le) begin
					s_nxt.st = ST_RUN;
					s_nxt.restart = 1'b1;
					s_nxt.hist_rst = 1'b1;
				end else if (motor_stopped) begin
					if (s_r.mode == STOP_DECEL_TRIP) begin
						s_nxt.st = ST_LINE_TRIP;
					end else begin
						s_nxt.st = ST_LINE_HOLD;
					end
				end
			end
			ST_LINE_HOLD: begin
				if (!le) begin
					s_nxt.st = ST_RUN;
					s_nxt.restart = 1'b1;
					s_nxt.hist_rst = 1'b1;
				end
			end
			ST_CIRC_DECEL: begin
				if (motor_stopped) begin
					s_nxt.st = ST_CIRC_TRIP;
				end
			end
			// Trips hold until drive reset, even if the link recovers
			ST_LINE_TRIP: begin
				s_nxt.st = ST_LINE_TRIP;
			end
			ST_CIRC_TRIP: begin
				s_nxt.st = ST_CIRC_TRIP;
			end
			default: begin
				s_nxt.st = ST_RUN;
			end
		endcase

		trip_nxt = (s_nxt.st == ST_LINE_TRIP) || (s_nxt.st == ST_CIRC_TRIP);
		if (trip_nxt && !s_r.alarm) begin
			s_nxt.hist_wr = 1'b1;
			s_nxt.code = (s_nxt.st == ST_LINE_TRIP) ? LINE_FAULT_CODE : CIRC_CODE;
		end
		// Trip states leave the output stage off
		s_nxt.coast = trip_nxt;
		// Deceleration follows the normal ramp; no separate error ramp
		s_nxt.decel = s_nxt.st inside {ST_LINE_DECEL, ST_LINE_HOLD, ST_CIRC_DECEL};
		s_nxt.alarm = trip_nxt;
		s_nxt.line_ind = (s_nxt.st == ST_LINE_TRIP);
		s_nxt.circ_ind = (s_nxt.st == ST_CIRC_TRIP);
		s_nxt.trip = trip_nxt || other_fault;
		s_nxt.halt = le || cf;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign coast_cmd = s_r.coast;
	assign decel_cmd = s_r.decel;
	assign accel_restart = s_r.restart;
	assign alarm_output = s_r.alarm;
	assign fault_bit = s_r.alarm;
	assign line_error_fault = s_r.line_ind;
	assign circuit_fault_ind = s_r.circ_ind;
	assign drive_trip = s_r.trip;
	assign comm_halt = s_r.halt;
	assign run_cmd_out = s_r.run_cmd;
	assign speed_cmd_out = s_r.speed;
	assign hist_write = s_r.hist_wr;
	assign hist_temp = s_r.hist_tmp;
	assign hist_restore = s_r.hist_rst;
	assign hist_code = s_r.code;
	assign error_count_value = lk.count;
	assign nv_save = lk.nv_save;
	assign nv_save_data = lk.nv_data;

	// ==========================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	fault_pair_a: assert property (alarm_output == fault_bit && alarm_output == (line_error_fault || circuit_fault_ind))
		else $error("alarm and fault bit disagree");
	short_error_a: assert property (s_r.st == ST_RUN && !lk.expired && !cf |=> !alarm_output && !decel_cmd)
		else $error("fault before wait expired");
	coast_trip_a: assert property (s_r.st == ST_RUN && net_mode && !cf && lk.expired && stop_mode_select == STOP_COAST
		|=> alarm_output && coast_cmd && hist_write && hist_code == LINE_FAULT_CODE)
		else $error("mode 0 did not trip at once");
	mode1_wait_a: assert property (s_r.st == ST_LINE_DECEL && s_r.mode == STOP_DECEL_TRIP && !motor_stopped
		|=> !alarm_output && decel_cmd)
		else $error("mode 1 fault before stop");
	mode2_quiet_a: assert property (s_r.mode == STOP_DECEL_RESUME && s_r.st inside {ST_LINE_DECEL, ST_LINE_HOLD}
		|-> !alarm_output && !line_error_fault)
		else $error("mode 2 showed a fault");
	trip_hold_a: assert property (alarm_output |=> alarm_output [*3])
		else $error("fault dropped without reset");
	circ_path_a: assert property (s_r.st == ST_RUN && cf && net_mode && stop_mode_select inside {STOP_DECEL_TRIP, STOP_DECEL_RESUME}
		|=> decel_cmd && !alarm_output)
		else $error("circuit fault did not decelerate");
	no_restart_a: assert property (s_r.st inside {ST_CIRC_DECEL, ST_CIRC_TRIP} |=> !accel_restart)
		else $error("restart after circuit fault");
	mid_decel_a: assert property (s_r.st == ST_LINE_DECEL && s_r.mode == STOP_DECEL_RESUME && !le
		|=> accel_restart && hist_restore && !decel_cmd)
		else $error("no restart on mid-decel clear");
	local_run_a: assert property (!net_mode && s_r.st == ST_RUN |=> s_r.st == ST_RUN ##0 comm_halt == $past(le || cf))
		else $error("local mode tripped");
	other_trip_a: assert property (other_fault |=> drive_trip)
		else $error("drive fault did not trip");
	hist_rise_a: assert property ($rose(alarm_output) |-> hist_write)
		else $error("fault output without record");
	cmd_frozen_a: assert property (s_r.st != ST_RUN || le |=> $stable(speed_cmd_out) && $stable(run_cmd_out))
		else $error("command changed during error");

	coast_seen_c: cover property (s_r.st == ST_RUN ##1 s_r.st == ST_LINE_TRIP);
	resume_seen_c: cover property (s_r.st == ST_LINE_DECEL ##[1:20] accel_restart);
	circ_decel_c: cover property (s_r.st == ST_CIRC_DECEL ##[1:20] s_r.st == ST_CIRC_TRIP);
	hold_resume_c: cover property (s_r.st == ST_LINE_HOLD ##1 accel_restart);

endmodule // comm_fault_ctrl

// ---- shared/comm_fault_pkg.sv ----
package comm_fault_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_MS = 100;
	localparam int TICK_NS = TICK_MS * 1000 * 1000;
	localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
	localparam int SAVE_PERIOD_S = 3600;
	localparam int HOUR_TICKS_DEF = SAVE_PERIOD_S * 1000 / TICK_MS;

	// ==========================================================
	// Widths and limits
	localparam int TICK_W = 25;
	localparam int HOUR_W = 16;
	localparam int WAIT_W = 14;
	localparam int COUNT_W = 16;
	localparam int SPEED_W = 16;
	localparam int CODE_W = 8;
	localparam logic [WAIT_W-1:0] WAIT_MAX = 14'h270e;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

	// ==========================================================
	// Fault data codes
	localparam logic [CODE_W-1:0] LINE_FAULT_CODE = 8'ha1;
	// Arbitrary default for the link circuit fault code
	localparam logic [CODE_W-1:0] CIRC_FAULT_CODE_DEF = 8'h01;

	// ==========================================================
	// Modes and states
	typedef enum logic [1:0] {
		STOP_COAST = 2'b00,
		STOP_DECEL_TRIP = 2'b01,
		STOP_DECEL_RESUME = 2'b10,
		STOP_CONTINUE = 2'b11
	} stop_mode_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_LINE_DECEL = 3'b001,
		ST_LINE_TRIP = 3'b010,
		ST_LINE_HOLD = 3'b011,
		ST_CIRC_DECEL = 3'b101,
		ST_CIRC_TRIP = 3'b110
	} ctrl_state_t;

endpackage

// ---- shared/comm_fault_if.sv ----
interface comm_fault_if;
	import comm_fault_pkg::*;

	logic line_err_s;
	logic [WAIT_W-1:0] wait_time;
	logic tick;
	logic expired;
	logic clear_req;
	logic [COUNT_W-1:0] nv_load;
	logic [COUNT_W-1:0] count;
	logic nv_save;
	logic [COUNT_W-1:0] nv_data;

	modport timer_mp (input line_err_s, input wait_time, output tick, output expired);
	modport counter_mp (input line_err_s, input tick, input clear_req, input nv_load,
		output count, output nv_save, output nv_data);
	modport ctrl_mp (output line_err_s, output wait_time, output clear_req, output nv_load,
		input tick, input expired, input count, input nv_save, input nv_data);

endinterface

// ---- hw/wait_timer.sv ----
module wait_timer #(
	parameter int unsigned TICK_CYCLES = comm_fault_pkg::TICK_CYCLES_DEF
) (
	input wire logic ref_clk,
	input wire logic rstn,
	comm_fault_if.timer_mp lk
);
	import comm_fault_pkg::*;

	typedef struct packed {
		logic [TICK_W-1:0] pre;
		logic tick;
		logic [WAIT_W-1:0] cnt;
		logic expired;
	} timer_t;

	timer_t s_r, s_nxt;

	// ==========================================================
	// Tenth-second tick and wait measurement
	// Free-running tick: the wait may end up to one tick early
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.pre == TICK_W'(TICK_CYCLES - 1)) begin
			s_nxt.pre = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.pre = s_r.pre + 1'b1;
		end
		if (!lk.line_err_s) begin
			s_nxt.cnt = '0;
			s_nxt.expired = 1'b0;
		end else if (s_r.cnt >= lk.wait_time) begin
			s_nxt.expired = 1'b1;
		end else if (s_r.tick) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.tick = s_r.tick;
	assign lk.expired = s_r.expired;

	// ==========================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	wait_restart_a: assert property (!lk.line_err_s |=> !lk.expired && s_r.cnt == '0)
		else $error("wait measurement not restarted");
	expire_cause_a: assert property ($rose(lk.expired) |-> $past(lk.line_err_s) && $past(s_r.cnt) >= $past(lk.wait_time))
		else $error("expired without full wait");

endmodule // wait_timer

// ---- hw/err_counter.sv ----
module err_counter #(
	parameter int unsigned HOUR_TICKS = comm_fault_pkg::HOUR_TICKS_DEF
) (
	input wire logic ref_clk,
	input wire logic rstn,
	comm_fault_if.counter_mp lk
);
	import comm_fault_pkg::*;

	typedef struct packed {
		logic loaded;
		logic prev_err;
		logic [COUNT_W-1:0] cnt;
		logic [HOUR_W-1:0] hr;
		logic save;
		logic [COUNT_W-1:0] nv_data;
	} counter_t;

	counter_t s_r, s_nxt;
	logic occur;

	// ==========================================================
	// Volatile count, hourly copy to nonvolatile store
	always_comb begin
		s_nxt = s_r;
		s_nxt.save = 1'b0;
		s_nxt.prev_err = lk.line_err_s;
		occur = lk.line_err_s && !s_r.prev_err;
		if (!s_r.loaded) begin
			s_nxt.loaded = 1'b1;
			s_nxt.cnt = lk.nv_load;
		end else begin
			if (lk.clear_req) begin
				s_nxt.cnt = '0;
			end
			// An occurrence in the clearing cycle still counts
			if (occur && lk.clear_req) begin
				s_nxt.cnt = COUNT_ONE;
			end else if (occur && s_r.cnt != COUNT_MAX) begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
			if (lk.tick) begin
				if (s_r.hr == HOUR_W'(HOUR_TICKS - 1)) begin
					s_nxt.hr = '0;
					s_nxt.save = 1'b1;
					s_nxt.nv_data = s_r.cnt;
				end else begin
					s_nxt.hr = s_r.hr + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.count = s_r.cnt;
	assign lk.nv_save = s_r.save;
	assign lk.nv_data = s_r.nv_data;

	// ==========================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	count_up_a: assert property (s_r.loaded && occur && !lk.clear_req && s_r.cnt != COUNT_MAX
		|=> s_r.cnt == $past(s_r.cnt) + 1'b1)
		else $error("count missed an occurrence");
	count_clear_a: assert property (s_r.loaded && lk.clear_req && !occur |=> s_r.cnt == '0)
		else $error("count not cleared");
	count_load_a: assert property ($rose(s_r.loaded) |-> s_r.cnt == $past(lk.nv_load))
		else $error("count not restored from store");
	save_tick_a: assert property (lk.nv_save |-> $past(lk.tick) && $past(s_r.hr) == HOUR_W'(HOUR_TICKS - 1))
		else $error("save outside hour boundary");

endmodule // err_counter

// ---- verification/link_master_model.sv ----
module link_master_model (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic out_go,
	input wire logic [15:0] out_len,
	input wire logic zero_go,
	output logic line_err_pin,
	output logic count_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] left_r;

	// ==========================================================
	// Line outage generator; a new out_go reloads the length, even during an outage
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			line_err_pin <= 1'b0;
			left_r <= 16'h0000;
			count_clear <= 1'b0;
		end else begin
			if (out_go) begin
				line_err_pin <= 1'b1;
				left_r <= out_len;
			end else if (left_r != 16'h0000) begin
				left_r <= left_r - 16'h0001;
			end else begin
				line_err_pin <= 1'b0;
			end
			count_clear <= zero_go;
		end
	end
endmodule // link_master_model

// ---- verification/tb_comm_fault_ctrl.sv ----
module tb_comm_fault_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import comm_fault_pkg::*;
	// Arbitrary circuit fault code
	localparam logic [CODE_W-1:0] CODE_C = 8'h5c;
	logic ref_clk, rstn, line_err_pin, circ_fault_pin, other_fault, net_mode, count_clear, run_cmd_in;
	logic motor_stopped = 1'b0;
	logic [WAIT_W-1:0] error_wait_time;
	stop_mode_t stop_mode_select;
	logic [COUNT_W-1:0] nv_count_in, error_count_value, nv_save_data;
	logic [SPEED_W-1:0] speed_cmd_in, speed_cmd_out;
	logic coast_cmd, decel_cmd, accel_restart, alarm_output, fault_bit, line_error_fault, circuit_fault_ind;
	logic drive_trip, comm_halt, run_cmd_out, hist_write, hist_temp, hist_restore, nv_save;
	logic [CODE_W-1:0] hist_code;
	logic out_go, zero_go;
	logic [15:0] out_len;
	int err_total, cmp_count, exp_count, stop_cnt, hw_n, tmp_n, res_n, rs_n;
	logic [COUNT_W-1:0] saved_q[$];

	comm_fault_ctrl #(.TICK_CYCLES(4), .HOUR_TICKS(5), .CIRC_CODE(CODE_C)) i_comm_fault_ctrl (
		.ref_clk, .rstn, .line_err_pin, .circ_fault_pin, .other_fault, .net_mode, .error_wait_time,
		.stop_mode_select, .motor_stopped, .count_clear, .nv_count_in, .run_cmd_in, .speed_cmd_in,
		.coast_cmd, .decel_cmd, .accel_restart, .alarm_output, .fault_bit, .line_error_fault,
		.circuit_fault_ind, .drive_trip, .comm_halt, .run_cmd_out, .speed_cmd_out, .hist_write,
		.hist_temp, .hist_restore, .hist_code, .error_count_value, .nv_save, .nv_save_data);

	link_master_model i_link_master_model (.ref_clk, .rstn, .out_go, .out_len, .zero_go, .line_err_pin, .count_clear);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Pulse counters and a crude motor: stops 30 cycles into any braking
	// Sampled on the falling edge so registered pulses are settled
	always @(negedge ref_clk) begin
		hw_n += int'(hist_write === 1'b1);
		tmp_n += int'(hist_temp === 1'b1);
		res_n += int'(hist_restore === 1'b1);
		rs_n += int'(accel_restart === 1'b1);
		if (nv_save === 1'b1) saved_q.push_back(nv_save_data);
		stop_cnt <= (decel_cmd === 1'b1 || coast_cmd === 1'b1) ? stop_cnt + 1 : 0;
		motor_stopped <= (stop_cnt >= 30);
	end

	// ==========================================================
	// Compare and sequencing helpers
	task automatic chk1(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic reset_dut(input stop_mode_t m, input logic [WAIT_W-1:0] w, input logic nm);
		@(posedge ref_clk);
		rstn <= 1'b0;
		stop_mode_select <= m;
		error_wait_time <= w;
		net_mode <= nm;
		other_fault <= 1'b0;
		circ_fault_pin <= 1'b0;
		nv_count_in <= 16'($urandom);
		speed_cmd_in <= 16'($urandom);
		run_cmd_in <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		cyc(4);
		exp_count = int'(nv_count_in);
		chk16(error_count_value, 16'(exp_count), "count after reset");
		chk1(alarm_output, 1'b0, "alarm after reset");
	endtask

	task automatic outage(input int n);
		@(posedge ref_clk);
		out_len <= 16'(n);
		out_go <= 1'b1;
		@(posedge ref_clk);
		out_go <= 1'b0;
		exp_count = (exp_count == 65535) ? exp_count : exp_count + 1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic line_case(input stop_mode_t m);
		logic [SPEED_W-1:0] spd;
		int h0, r0;
		reset_dut(m, 14'h0000, 1'b1);
		spd = speed_cmd_in;
		h0 = hw_n;
		r0 = rs_n;
		outage((m == STOP_DECEL_RESUME) ? 16 : 150);
		cyc(10);
		@(posedge ref_clk);
		speed_cmd_in <= ~spd;
		run_cmd_in <= 1'b0;
		cyc(2);
		chk1(alarm_output, m == STOP_COAST, "alarm at expiry");
		chk1(fault_bit, m == STOP_COAST, "fault bit at expiry");
		chk1(coast_cmd, m == STOP_COAST, "coast at expiry");
		chk1(decel_cmd, m == STOP_DECEL_TRIP || m == STOP_DECEL_RESUME, "decel at expiry");
		chk1(comm_halt, 1'b1, "halt on line error");
		if (m == STOP_DECEL_TRIP) begin
			chk1(line_error_fault, 1'b0, "indication before stop");
			while (motor_stopped !== 1'b1 && stop_cnt < 80) cyc(1);
			cyc(3);
			chk1(alarm_output, 1'b1, "alarm after stop");
		end
		if (m == STOP_DECEL_RESUME) begin
			chk16(speed_cmd_out, spd, "frozen speed");
			chk1(run_cmd_out, 1'b1, "frozen run command");
			cyc(20);
			chk16(speed_cmd_out, ~spd, "command tracked after restart");
			chk1(run_cmd_out, 1'b0, "run command tracked after restart");
			chk1(tmp_n == 1 && res_n == 1, 1'b1, "temporary record restored");
			chk1(rs_n - r0 == 1, 1'b1, "restart mid deceleration");
			chk1(line_error_fault, 1'b0, "normal indication after restart");
			chk1(decel_cmd, 1'b0, "decel after restart");
		end else begin
			cyc(160);
			chk1(alarm_output, m <= STOP_DECEL_TRIP, "alarm after clear");
			chk1(line_error_fault, m <= STOP_DECEL_TRIP, "indication after clear");
			chk1(hw_n - h0 == int'(m <= STOP_DECEL_TRIP), 1'b1, "history commit");
			if (m <= STOP_DECEL_TRIP) chk16({8'h00, hist_code}, {8'h00, LINE_FAULT_CODE}, "line code");
			chk1(rs_n == r0, 1'b1, "no restart");
		end
		tmp_n = 0;
		res_n = 0;
	endtask

	task automatic circ_case(input stop_mode_t m);
		int r0;
		logic now;
		reset_dut(m, 14'h0005, 1'b1);
		r0 = rs_n;
		now = (m == STOP_COAST || m == STOP_CONTINUE);
		@(posedge ref_clk);
		circ_fault_pin <= 1'b1;
		cyc(8);
		chk1(circuit_fault_ind, now, "circuit indication");
		chk1(coast_cmd, now, "circuit coast");
		chk1(decel_cmd, !now, "circuit decel");
		chk1(comm_halt, 1'b1, "halt on circuit fault");
		while (motor_stopped !== 1'b1 && stop_cnt < 80) cyc(1);
		cyc(3);
		@(posedge ref_clk);
		circ_fault_pin <= 1'b0;
		cyc(12);
		chk1(alarm_output, 1'b1, "circuit alarm kept");
		chk1(circuit_fault_ind, 1'b1, "circuit indication kept");
		chk16({8'h00, hist_code}, {8'h00, CODE_C}, "circuit code");
		chk1(rs_n == r0, 1'b1, "no circuit restart");
	endtask

	task automatic count_case();
		reset_dut(STOP_COAST, 14'h0003, 1'b1);
		outage(3);
		cyc(8);
		outage(3);
		cyc(20);
		chk1(alarm_output, 1'b0, "short outages");
		chk1(line_error_fault, 1'b0, "wait restarted");
		chk16(error_count_value, 16'(exp_count), "count per outage");
		@(posedge ref_clk);
		zero_go <= 1'b1;
		@(posedge ref_clk);
		zero_go <= 1'b0;
		exp_count = 0;
		cyc(4);
		chk16(error_count_value, 16'(exp_count), "count cleared");
		outage(3);
		cyc(10);
		saved_q.delete();
		cyc(30);
		chk1(saved_q.size() inside {1, 2}, 1'b1, "save rate");
		if (saved_q.size() > 0) chk16(saved_q[0], 16'(exp_count), "saved count");
		outage(60);
		cyc(30);
		chk1(alarm_output, 1'b1, "long outage");
	endtask

	task automatic local_case();
		reset_dut(STOP_COAST, 14'h0000, 1'b0);
		outage(40);
		cyc(12);
		chk1(comm_halt, 1'b1, "local halt");
		chk1(drive_trip, 1'b0, "local runs on");
		cyc(40);
		@(posedge ref_clk);
		other_fault <= 1'b1;
		cyc(3);
		chk1(drive_trip, 1'b1, "other fault trips");
		chk1(comm_halt, 1'b0, "link continues");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		rstn = 1'b0;
		{circ_fault_pin, other_fault, net_mode, out_go, zero_go} = 5'h00;
		run_cmd_in = 1'b1;
		error_wait_time = 14'h0000;
		stop_mode_select = STOP_COAST;
		out_len = 16'h0000;
		nv_count_in = 16'h0000;
		speed_cmd_in = 16'h0000;
		void'($urandom(32'haa6e_396e));
		for (int m = 0; m < 4; m++) line_case(stop_mode_t'(m));
		for (int m = 0; m < 4; m++) circ_case(stop_mode_t'(m));
		count_case();
		local_case();
		conclude();
	end

	initial begin
		#100000;
		err_total++;
		conclude();
	end
endmodule // tb_comm_fault_ctrl
